/* File: rtl/lpmc_top.sv */
// Purpose: sleep and standby sequencing, supply monitor and reset hold
// Assumes: all inputs synchronous to clk, rstn is the power-on reset
// Notes:   every output registered; the bus must stay idle while clkEn is low
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module lpmc_top import lpmc_pkg::*; #(
   parameter int LINES      = EVENT_LINES,
   parameter int RESET_HOLD = RESET_HOLD_CYC
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              clkEn,
   // register bus
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [DATA_W-1:0] hwdata,
   output logic                   hreadyout,
   output logic      [DATA_W-1:0] hrdata,
   output logic                   hresp,
   // cpu side
   input  wire logic              cpuWaitReq,
   input  wire logic              irqPending,
   input  wire logic              wakeEvent,
   // wake and reset sources
   input  wire logic [LINES-1:0]  extEventLines,
   input  wire logic              autoWakeup,
   input  wire logic              watchdogReset,
   input  wire logic              extResetPin_n,
   input  wire logic              supplyBelowPor,
   input  wire logic              supplyBelowMonitor,
   // power and clock controls, system reset, monitor and interrupt outputs
   output logic                   cpuClkEn,
   output logic                   periphClkEn,
   output logic                   corePowerEn,
   output logic                   intFastOscEn,
   output logic                   extFastOscEn,
   output logic                   sysClkSelExt,
   output logic                   regulatorOn,
   output logic                   regulatorLowPower,
   output logic                   sysReset_n,
   output logic                   monitorOut,
   output logic                   irq
);
   localparam int CNT_W = $clog2(RESET_HOLD + 1);

   if (LINES < 1 || LINES > 32) begin : gBadLines
      $error("lpmc_top: LINES must be 1 to 32");
   end
   if (RESET_HOLD < 1) begin : gBadHold
      $error("lpmc_top: RESET_HOLD must be at least 1");
   end

   lpmc_mode_t          state;
   lpmc_mode_t          next_state;
   logic [CTRL_W-1:0]   ctrl;
   logic [CTRL_W-1:0]   next_ctrl;
   logic [EV_W-1:0]     status;
   logic [EV_W-1:0]     next_status;
   logic [EV_W-1:0]     mask;
   logic [EV_W-1:0]     next_mask;
   logic [EV_W-1:0]     events;
   logic [CAUSE_W-1:0]  cause;
   logic [CAUSE_W-1:0]  stbyCause;
   logic [CNT_W-1:0]    holdCnt;
   logic [LINES-1:0]    lineRise;
   logic                monRise;
   logic                monFall;
   logic                monEdge;
   logic                resetReq;
   logic                sleepWake;
   logic                sleepExit;
   logic                stbyExit;
   logic                deepStop;
   logic                wrCtrl;
   logic                wrMask;
   logic                rdStatus;

   lpmc_reg_if regBus ();

   lpmc_ahb_slave u_bus (
      .clk       (clk),
      .rstn      (rstn),
      .clkEn     (clkEn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .bus       (regBus)
   );

   lpmc_edge #(.WIDTH(1)) u_monEdge (
      .clk   (clk),
      .rstn  (rstn),
      .clkEn (clkEn),
      .en    (ctrl[CTRL_MON_EN]),
      .sig   (supplyBelowMonitor),
      .rise  (monRise),
      .fall  (monFall)
   );

   lpmc_edge #(.WIDTH(LINES)) u_lineEdge (
      .clk   (clk),
      .rstn  (rstn),
      .clkEn (clkEn),
      .en    (1'b1),
      .sig   (extEventLines),
      .rise  (lineRise),
      .fall  ()
   );

   assign monEdge = monRise | monFall;

   assign resetReq = supplyBelowPor | ~extResetPin_n | watchdogReset;

   assign sleepWake = irqPending | wakeEvent | (|lineRise) | monEdge | autoWakeup;

   always_comb begin
      stbyCause              = '0;
      stbyCause[CAUSE_LINES] = |lineRise;
      stbyCause[CAUSE_MON]   = monEdge;
      stbyCause[CAUSE_AUTO]  = autoWakeup;
      stbyCause[CAUSE_PIN]   = ~extResetPin_n;
      stbyCause[CAUSE_WDG]   = watchdogReset;
   end

   assign deepStop = ctrl[CTRL_PD_DEEP] & ctrl[CTRL_DEEP];

   always_comb begin
      next_state = state;
      case (state)
         MODE_RUN: begin
            if (cpuWaitReq) begin
               next_state = deepStop ? MODE_STANDBY : MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            if (sleepWake) begin
               next_state = MODE_RUN;
            end
         end
         MODE_STANDBY: begin
            if (|stbyCause) begin
               next_state = MODE_RESTART;
            end
         end
         MODE_RESTART: begin
            if (holdCnt == '0 && !resetReq) begin
               next_state = MODE_RUN;
            end
         end
         default: begin
            next_state = MODE_RESTART;
         end
      endcase
      if (resetReq) begin
         next_state = MODE_RESTART;
      end
   end

   assign sleepExit = (state == MODE_SLEEP) && (next_state != MODE_SLEEP);
   assign stbyExit  = (state == MODE_STANDBY) && (next_state != MODE_STANDBY);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= MODE_RESTART;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         holdCnt <= CNT_W'(RESET_HOLD);
      end else if (clkEn) begin
         if (state != MODE_RESTART || resetReq) begin
            holdCnt <= CNT_W'(RESET_HOLD);
         end else if (holdCnt != '0) begin
            holdCnt <= holdCnt - CNT_W'(1);
         end
      end
   end

   assign wrCtrl   = regBus.wrEn && (regBus.wrAddr == OFF_CTRL);
   assign wrMask   = regBus.wrEn && (regBus.wrAddr == OFF_MASK);
   assign rdStatus = regBus.rdEn && (regBus.rdAddr == OFF_STATUS);

   always_comb begin
      next_ctrl = ctrl;
      if (wrCtrl) begin
         next_ctrl = regBus.wdata[CTRL_W-1:0];
      end
      if (sleepExit || stbyExit) begin
         next_ctrl[CTRL_CLK_EXT] = 1'b0;
      end
      if (stbyExit) begin
         next_ctrl[CTRL_PD_DEEP] = 1'b0;
         next_ctrl[CTRL_DEEP] = 1'b0;
      end
   end

   always_comb begin
      events                = '0;
      events[EV_MON_FELL]   = monRise;
      events[EV_MON_ROSE]   = monFall;
      events[EV_SLEEP_WAKE] = sleepExit;
      events[EV_STBY_WAKE]  = stbyExit;
   end

   always_comb begin
      next_status = rdStatus ? '0 : status;
      next_status = next_status | events;
      next_mask   = wrMask ? regBus.wdata[EV_W-1:0] : mask;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl   <= CTRL_RST;
         status <= EV_RST;
         mask   <= EV_RST;
      end else if (clkEn) begin
         ctrl   <= next_ctrl;
         status <= next_status;
         mask   <= next_mask;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cause <= CAUSE_RST;
      end else if (clkEn) begin
         if (stbyExit) begin
            cause <= stbyCause;
         end
      end
   end

   always_comb begin
      regBus.rdata = '0;
      case (regBus.rdAddr)
         OFF_CTRL: begin
            regBus.rdata[CTRL_W-1:0] = ctrl;
         end
         OFF_STATUS: begin
            regBus.rdata[EV_W-1:0] = status;
         end
         OFF_MASK: begin
            regBus.rdata[EV_W-1:0] = mask;
         end
         OFF_STATE: begin
            regBus.rdata[ST_MODE_LSB +: MODE_W]  = state;
            regBus.rdata[ST_MON_OUT]             = monitorOut;
            regBus.rdata[ST_CAUSE_LSB +: CAUSE_W] = cause;
         end
         default: begin
            regBus.rdata = '0;
         end
      endcase
   end

   // clock and power controls
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpuClkEn     <= 1'b0;
         periphClkEn  <= 1'b1;
         corePowerEn  <= 1'b1;
         intFastOscEn <= 1'b1;
         extFastOscEn <= 1'b0;
         sysClkSelExt <= 1'b0;
      end else if (clkEn) begin
         // only cpu clock stops in sleep
         cpuClkEn     <= (next_state == MODE_RUN);
         periphClkEn  <= (next_state != MODE_STANDBY);
         corePowerEn  <= (next_state != MODE_STANDBY);
         intFastOscEn <= (next_state != MODE_STANDBY);
         extFastOscEn <= (next_state != MODE_STANDBY) && next_ctrl[CTRL_CLK_EXT];
         sysClkSelExt <= (next_state != MODE_STANDBY) && next_ctrl[CTRL_CLK_EXT];
      end
   end

   // regulator and system reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regulatorOn       <= 1'b1;
         regulatorLowPower <= 1'b0;
         sysReset_n        <= 1'b0;
      end else if (clkEn) begin
         regulatorOn       <= (next_state != MODE_STANDBY);
         regulatorLowPower <= (next_state == MODE_STANDBY);
         sysReset_n        <= (next_state != MODE_RESTART);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         monitorOut <= 1'b0;
         irq        <= 1'b0;
      end else if (clkEn) begin
         monitorOut <= supplyBelowMonitor & next_ctrl[CTRL_MON_EN];
         irq        <= |(next_status & next_mask);
      end
   end
endmodule : lpmc_top
`default_nettype wire

/* File: rtl/lpmc_pkg.sv */
// Purpose: constants, register map and mode type of the low power mode controller
// Assumes: one 200 MHz clock, AHB-Lite register access, word accesses only
// Notes:   all registers one aligned word, narrow fields in the low bits
// Behaviour
// - sleep stops only the cpu clock; peripheral clocks keep running
// - any interrupt or wake event ends sleep and restarts the cpu clock
// - standby needs both deep select bits set, then a wait instruction
// - standby removes core power and stops both fast oscillators
// - standby ends on event lines, reset pin, watchdog, monitor, auto wakeup
// - voltage monitor compares only when enabled; disabled it gives nothing
// - with edge interrupt on, monitor flags both falling and rising supply
// - power down detector holds the whole chip in reset while supply low
// - after any reset the regulator comes on by itself in normal mode
// - deep stop request moves to standby with the regulator in low power
// - after any wake the internal fast oscillator becomes system clock
package lpmc_pkg;

   localparam int OFFS_W        = 8;
   localparam int DATA_W        = 32;
   localparam int EVENT_LINES   = 18;

   localparam logic [OFFS_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [OFFS_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [OFFS_W-1:0] OFF_MASK   = 8'h08;
   localparam logic [OFFS_W-1:0] OFF_STATE  = 8'h0C;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // control register fields
   localparam int CTRL_W        = 4;
   localparam int CTRL_PD_DEEP  = 0;
   localparam int CTRL_DEEP     = 1;
   localparam int CTRL_MON_EN   = 2;
   localparam int CTRL_CLK_EXT  = 3;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

   // event bits, shared by status and mask
   localparam int EV_W          = 4;
   localparam int EV_MON_FELL   = 0;
   localparam int EV_MON_ROSE   = 1;
   localparam int EV_SLEEP_WAKE = 2;
   localparam int EV_STBY_WAKE  = 3;
   localparam logic [EV_W-1:0] EV_RST = 4'h0;

   // state register fields
   localparam int MODE_W        = 2;
   localparam int ST_MODE_LSB   = 0;
   localparam int ST_MON_OUT    = 2;
   localparam int ST_CAUSE_LSB  = 4;
   localparam int CAUSE_W       = 5;
   localparam int CAUSE_LINES   = 0;
   localparam int CAUSE_MON     = 1;
   localparam int CAUSE_AUTO    = 2;
   localparam int CAUSE_PIN     = 3;
   localparam int CAUSE_WDG     = 4;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h00;

   // timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int RESET_HOLD_NS  = 100;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [MODE_W-1:0] {
      MODE_RUN,
      MODE_SLEEP,
      MODE_STANDBY,
      MODE_RESTART
   } lpmc_mode_t;

endpackage : lpmc_pkg

/* File: rtl/lpmc_reg_if.sv */
// Purpose: register access carrier between bus slave and controller core
// Assumes: read data answered combinationally in the address phase
// Notes:   write strobe is one cycle, in the data phase
`timescale 1ns/100ps
`default_nettype none
interface lpmc_reg_if import lpmc_pkg::*; ();
   logic              rdEn;
   logic [OFFS_W-1:0] rdAddr;
   logic [DATA_W-1:0] rdata;
   logic              wrEn;
   logic [OFFS_W-1:0] wrAddr;
   logic [DATA_W-1:0] wdata;

   modport bus  (output rdEn, rdAddr, wrEn, wrAddr, wdata, input rdata);
   modport regs (input rdEn, rdAddr, wrEn, wrAddr, wdata, output rdata);
endinterface : lpmc_reg_if
`default_nettype wire

/* File: rtl/lpmc_edge.sv */
// Purpose: registered rising and falling edge detection on a group of levels
// Assumes: inputs synchronous to clk
// Notes:   edges are suppressed while en is low, history still tracked
`timescale 1ns/100ps
`default_nettype none
module lpmc_edge #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             clkEn,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] sig,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] prev;

   if (WIDTH < 1) begin : gBadWidth
      $error("lpmc_edge: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev <= '0;
         rise <= '0;
         fall <= '0;
      end else if (clkEn) begin
         prev <= sig;
         rise <= {WIDTH{en}} & sig & ~prev;
         fall <= {WIDTH{en}} & ~sig & prev;
      end
   end
endmodule : lpmc_edge
`default_nettype wire

/* File: rtl/lpmc_ahb_slave.sv */
// Purpose: AHB-Lite slave front end for the controller registers
// Assumes: single word transfers, bus idle while clkEn is low
// Notes:   zero wait states, always OKAY, unmapped reads return zero
`timescale 1ns/100ps
`default_nettype none
module lpmc_ahb_slave import lpmc_pkg::*; (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              clkEn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [DATA_W-1:0] hwdata,
   output logic                   hreadyout,
   output logic      [DATA_W-1:0] hrdata,
   output logic                   hresp,
   lpmc_reg_if.bus                bus
);
   logic accept;

   assign accept     = clkEn & hsel & htrans[1] & hreadyout & (hsize == HSIZE_WORD);
   assign bus.rdEn   = accept & ~hwrite;
   assign bus.rdAddr = haddr[OFFS_W-1:0];
   assign bus.wdata  = hwdata;

   // address phase capture
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus.wrEn   <= 1'b0;
         bus.wrAddr <= '0;
      end else if (clkEn) begin
         bus.wrEn   <= accept & hwrite;
         bus.wrAddr <= haddr[OFFS_W-1:0];
      end
   end

   // read data and response
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clkEn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (bus.rdEn) begin
            hrdata <= bus.rdata;
         end
      end
   end
endmodule : lpmc_ahb_slave
`default_nettype wire

/* File: testbench/lpmc_chk.sv */
// Purpose: port assertions for the low power mode controller
// Assumes: clkEn held high
// Notes:   bound to lpmc_top
`timescale 1ns/100ps
`default_nettype none
module lpmc_chk import lpmc_pkg::*; #(
   parameter int LINES      = EVENT_LINES,
   parameter int RESET_HOLD = RESET_HOLD_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cpuWaitReq,
   input wire logic irqPending,
   input wire logic wakeEvent,
   input wire logic watchdogReset,
   input wire logic extResetPin_n,
   input wire logic supplyBelowPor,
   input wire logic supplyBelowMonitor,
   input wire logic cpuClkEn,
   input wire logic periphClkEn,
   input wire logic corePowerEn,
   input wire logic intFastOscEn,
   input wire logic extFastOscEn,
   input wire logic sysClkSelExt,
   input wire logic regulatorOn,
   input wire logic regulatorLowPower,
   input wire logic sysReset_n,
   input wire logic monitorOut
);
   logic [7:0] lowCnt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // cycles spent in reset hold
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) lowCnt <= 8'h00;
      else if (sysReset_n) lowCnt <= 8'h00;
      else if (lowCnt != 8'hFF) lowCnt <= lowCnt + 8'h01;
   end
   chk_sleep_clocks: assert property (!cpuClkEn && corePowerEn |-> periphClkEn)
      else $error("peripheral clock stopped while core powered");
   chk_sleep_wake: assert property (!cpuClkEn && corePowerEn && sysReset_n
      && (irqPending || wakeEvent) && extResetPin_n && !watchdogReset && !supplyBelowPor
      |=> cpuClkEn) else $error("sleep not left on wake");
   chk_standby_entry: assert property ($fell(corePowerEn)
      |-> $past(cpuWaitReq) && regulatorLowPower) else $error("bad standby entry");
   chk_standby_power: assert property (!corePowerEn |-> !intFastOscEn && !extFastOscEn
      && !cpuClkEn && !periphClkEn && regulatorLowPower) else $error("standby not off");
   chk_standby_exit: assert property (!corePowerEn && watchdogReset
      |=> corePowerEn && !sysReset_n) else $error("watchdog did not end standby");
   chk_monitor_gate: assert property (monitorOut |-> $past(supplyBelowMonitor))
      else $error("monitor output without low supply");
   chk_por_hold: assert property (supplyBelowPor |=> !sysReset_n && !cpuClkEn)
      else $error("low supply not held in reset");
   chk_reg_release: assert property ($rose(sysReset_n)
      |-> regulatorOn && !regulatorLowPower && intFastOscEn) else $error("bad release");
   chk_hold_length: assert property ($rose(sysReset_n) |-> lowCnt >= RESET_HOLD + 1)
      else $error("reset hold too short");
   chk_wake_clock: assert property ($rose(cpuClkEn) && $past(sysReset_n)
      |-> !sysClkSelExt) else $error("external clock kept after wake");
   cover property ($fell(corePowerEn));
   cover property ($rose(cpuClkEn) && $past(sysReset_n));
   cover property ($rose(monitorOut));
endmodule : lpmc_chk
bind lpmc_top lpmc_chk #(.LINES(LINES), .RESET_HOLD(RESET_HOLD)) chk_u (
   .clk(clk), .rstn(rstn), .cpuWaitReq(cpuWaitReq), .irqPending(irqPending),
   .wakeEvent(wakeEvent), .watchdogReset(watchdogReset), .extResetPin_n(extResetPin_n),
   .supplyBelowPor(supplyBelowPor), .supplyBelowMonitor(supplyBelowMonitor),
   .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .corePowerEn(corePowerEn),
   .intFastOscEn(intFastOscEn), .extFastOscEn(extFastOscEn), .sysClkSelExt(sysClkSelExt),
   .regulatorOn(regulatorOn), .regulatorLowPower(regulatorLowPower),
   .sysReset_n(sysReset_n), .monitorOut(monitorOut));
`default_nettype wire

/* File: testbench/lpmc_partner.sv */
// Purpose: cpu core and wake source model
// Assumes: driven just after rising edges
// Notes:   sources pulse for two cycles
`timescale 1ns/100ps
`default_nettype none
module lpmc_partner import lpmc_pkg::*; #(
   parameter int LINES = EVENT_LINES
) (
   input  wire logic             clk,
   input  wire logic             cpuClkEn,
   output logic                  cpuWaitReq,
   output logic                  irqPending,
   output logic                  wakeEvent,
   output logic      [LINES-1:0] extEventLines,
   output logic                  autoWakeup,
   output logic                  watchdogReset,
   output logic                  extResetPin_n,
   output logic                  supplyBelowPor,
   output logic                  supplyBelowMonitor
);
   initial begin
      {cpuWaitReq, irqPending, wakeEvent, autoWakeup, watchdogReset} = 5'h00;
      {supplyBelowPor, supplyBelowMonitor} = 2'h0;
      extEventLines = '0;
      extResetPin_n = 1'b1;
   end
   // wait only from a running cpu
   task automatic wfi();
      int n;
      n = 0;
      while (cpuClkEn !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n >= 100) begin
         testbench.n_errors++;
         testbench.wrap_up();
      end
      @(posedge clk);
      cpuWaitReq <= 1'b1;
      @(posedge clk);
      cpuWaitReq <= 1'b0;
   endtask : wfi
   // one wake source for two cycles
   task automatic poke(input int k, input int idx);
      @(posedge clk);
      case (k)
         0: irqPending <= 1'b1;
         1: wakeEvent <= 1'b1;
         2: extEventLines[idx] <= 1'b1;
         3: autoWakeup <= 1'b1;
         4: watchdogReset <= 1'b1;
         default: extResetPin_n <= 1'b0;
      endcase
      repeat (2) @(posedge clk);
      {irqPending, wakeEvent, autoWakeup, watchdogReset} <= 4'h0;
      extEventLines <= '0;
      extResetPin_n <= 1'b1;
   endtask : poke
   task automatic supply(input logic por, input logic mon);
      @(posedge clk);
      supplyBelowPor     <= por;
      supplyBelowMonitor <= mon;
   endtask : supply
endmodule : lpmc_partner
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: self checking bench for the low power mode controller
// Assumes: reset hold shortened to 2
// Notes:   reads are checked from a queue of expected words
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
`define WAITC(c) begin w = 0; while (!(c) && w < 200) begin @(posedge clk); w++; end \
   if (w >= 200) begin n_errors++; \
   $display("mismatch at %0t: wait timed out", $time); wrap_up(); end #1; end
module testbench import lpmc_pkg::*;;
   localparam int HOLD = 2;
   logic              clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPhase = 1'b0;
   logic [31:0]       haddr = 32'h0000_0000;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = HSIZE_WORD;
   logic [DATA_W-1:0] hwdata = '0, hrdata, expV;
   logic              hreadyout, cpuWaitReq, irqPending, wakeEvent, autoWakeup, watchdogReset;
   logic              extResetPin_n, supplyBelowPor, supplyBelowMonitor, irq, monitorOut, hresp;
   logic              cpuClkEn, periphClkEn, corePowerEn, intFastOscEn, extFastOscEn;
   logic              sysClkSelExt, regulatorOn, regulatorLowPower, sysReset_n;
   logic [EVENT_LINES-1:0] extEventLines;
   logic [DATA_W-1:0] expQ[$];
   int                n_errors = 0, n_compared = 0, w;
   int                cause[4] = '{CAUSE_LINES, CAUSE_AUTO, CAUSE_WDG, CAUSE_PIN};
   logic [7:0]        a;
   always #2.5 clk = ~clk;
   lpmc_top #(.RESET_HOLD(HOLD)) dut_u (.clk(clk), .rstn(rstn), .clkEn(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpuWaitReq(cpuWaitReq),
      .irqPending(irqPending), .wakeEvent(wakeEvent), .extEventLines(extEventLines),
      .autoWakeup(autoWakeup), .watchdogReset(watchdogReset), .extResetPin_n(extResetPin_n),
      .supplyBelowPor(supplyBelowPor), .supplyBelowMonitor(supplyBelowMonitor),
      .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .corePowerEn(corePowerEn),
      .intFastOscEn(intFastOscEn), .extFastOscEn(extFastOscEn), .sysClkSelExt(sysClkSelExt),
      .regulatorOn(regulatorOn), .regulatorLowPower(regulatorLowPower),
      .sysReset_n(sysReset_n), .monitorOut(monitorOut), .irq(irq));
   lpmc_partner partner_u (.clk(clk), .cpuClkEn(cpuClkEn), .cpuWaitReq(cpuWaitReq),
      .irqPending(irqPending), .wakeEvent(wakeEvent), .extEventLines(extEventLines),
      .autoWakeup(autoWakeup), .watchdogReset(watchdogReset), .extResetPin_n(extResetPin_n),
      .supplyBelowPor(supplyBelowPor), .supplyBelowMonitor(supplyBelowMonitor));
   task automatic wrap_up();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   task automatic wait_ready();
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (hreadyout !== 1'b1 && w < 200);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: ready timed out", $time);
         wrap_up();
      end
   endtask : wait_ready
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [DATA_W-1:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite, hsize} <= {1'b1, 2'b10, wr, HSIZE_WORD};
      haddr <= {24'h00_0000, ad};
      wait_ready();
      {hsel, htrans, hwdata, rdPhase} <= {1'b0, 2'b00, d, !wr};
      wait_ready();
      rdPhase <= 1'b0;
   endtask : ahb
   task automatic wr(input logic [7:0] ad, input logic [DATA_W-1:0] d);
      ahb(1'b1, ad, d);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [DATA_W-1:0] e);
      expQ.push_back(e);
      ahb(1'b0, ad, '0);
   endtask : rd
   always @(posedge clk) begin
      if (rdPhase === 1'b1) begin
         expV = expQ.pop_front();
         `CHK({hresp, hrdata}, {1'b0, expV})
      end
   end
   initial begin
      void'($urandom(87556));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      `WAITC(sysReset_n === 1'b1)
      `CHK({regulatorOn, regulatorLowPower, intFastOscEn}, 3'h5)
      for (int i = 0; i < 4; i++) rd(8'(i * 4), '0);
      a = 8'h10 + 8'($urandom % 60) * 8'h04;
      wr(a, $urandom);
      rd(a, '0);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_CTRL, 32'h0000_0008);
         partner_u.wfi();
         #1;
         `CHK({cpuClkEn, periphClkEn, sysClkSelExt, extFastOscEn}, 4'h7)
         rd(OFF_STATE, 32'h0000_0001);
         partner_u.poke(k, $urandom % EVENT_LINES);
         `WAITC(cpuClkEn === 1'b1)
         `CHK({sysClkSelExt, extFastOscEn}, 2'h0)
         rd(OFF_STATUS, 32'h0000_0004);
      end
      for (int c = 1; c < 3; c++) begin
         wr(OFF_CTRL, 32'(c));
         partner_u.wfi();
         #1;
         `CHK({corePowerEn, cpuClkEn}, 2'h2)
         partner_u.poke(1, 0);
         `WAITC(cpuClkEn === 1'b1)
         rd(OFF_STATUS, 32'h0000_0004);
      end
      for (int j = 0; j < 4; j++) begin
         wr(OFF_CTRL, 32'h0000_000B);
         partner_u.wfi();
         #1;
         `CHK({corePowerEn, intFastOscEn, extFastOscEn, cpuClkEn}, 4'h0)
         `CHK(regulatorLowPower, 1'b1)
         partner_u.poke(j + 2, $urandom % EVENT_LINES);
         #1;
         `CHK(sysReset_n, 1'b0)
         `WAITC(sysReset_n === 1'b1)
         `CHK({sysClkSelExt, intFastOscEn, regulatorOn}, 3'h3)
         rd(OFF_STATE, 32'h0000_0001 << (ST_CAUSE_LSB + cause[j]));
         rd(OFF_STATUS, 32'h0000_0008);
         rd(OFF_CTRL, 32'h0000_0000);
      end
      partner_u.supply(1'b0, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      `CHK(monitorOut, 1'b0)
      rd(OFF_STATUS, 32'h0000_0000);
      wr(OFF_MASK, 32'h0000_0003);
      wr(OFF_CTRL, 32'h0000_0004);
      partner_u.supply(1'b0, 1'b0);
      `WAITC(irq === 1'b1)
      rd(OFF_STATUS, 32'h0000_0002);
      partner_u.supply(1'b0, 1'b1);
      `WAITC(irq === 1'b1)
      `CHK(monitorOut, 1'b1)
      rd(OFF_STATUS, 32'h0000_0001);
      wr(OFF_MASK, 32'h0000_0000);
      partner_u.supply(1'b0, 1'b0);
      `WAITC(monitorOut === 1'b0)
      repeat (3) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      rd(OFF_STATUS, 32'h0000_0002);
      partner_u.supply(1'b1, 1'b0);
      repeat (31) @(posedge clk);
      #1;
      `CHK({sysReset_n, cpuClkEn}, 2'h0)
      partner_u.supply(1'b0, 1'b0);
      `WAITC(sysReset_n === 1'b1)
      @(posedge clk);
      rstn <= 1'b0;
      #1;
      `CHK({sysReset_n, cpuClkEn, periphClkEn, regulatorOn}, 4'h3)
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      `WAITC(sysReset_n === 1'b1)
      rd(OFF_CTRL, 32'h0000_0000);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
